// ==== pkg/dsbr_pkg.sv ====
// Constants, types and carriers of the phase-aligning, bit-slip receive channel.
// Contract
// - Phase selector tracks clock-to-data phase continuously.
// - Per-channel synchronizer FIFO, four deep, word wide.
// - FIFO written on parallel, read on global.
// - FIFO runs free, no flags, no enables.
// - Realignment on parallel words, per channel.
// - Each slip rising edge shifts one bit.
// - Realigner always in path, else latency only.
// - Deserialization factor selectable as 8 or 10.
// - Counter wraps to 0, word from later register.
// - Eight equally spaced phases, one-eighth UI.
package dsbr_pkg;

  localparam int unsigned DSBR_CLK_MHZ = 100;
  localparam int unsigned DSBR_LINK_PERIOD_NS = 80;
  localparam int unsigned DSBR_PHASES = (DSBR_LINK_PERIOD_NS * DSBR_CLK_MHZ) / 1000;
  localparam int unsigned DSBR_PH_W = 3;
  localparam logic [DSBR_PH_W-1:0] DSBR_PH_HALF = 3'h4;
  localparam logic [DSBR_PH_W-1:0] DSBR_PH_LAST = DSBR_PH_W'(DSBR_PHASES - 1);
  localparam int unsigned DSBR_WMAX = 10;
  localparam logic [3:0] DSBR_J8 = 4'h8;
  localparam logic [3:0] DSBR_J10 = 4'ha;
  localparam int unsigned DSBR_FIFO_DEPTH = 4;
  localparam int unsigned DSBR_PTR_W = 2;
  localparam logic [DSBR_PTR_W-1:0] DSBR_WR_PTR_RST = 2'h2;
  localparam logic [DSBR_PTR_W-1:0] DSBR_RD_PTR_RST = 2'h0;
  localparam logic [3:0] DSBR_RD_BIT = 4'h4;
  localparam logic [4:0] DSBR_LOCK_EDGES = 5'h10;

  typedef logic [DSBR_WMAX-1:0] dsbr_word_t;

  typedef struct packed {
    dsbr_word_t data;
    logic valid;
  } dsbr_word_s;

  typedef enum logic [1:0] {
    DSBR_HUNT = 2'b01,
    DSBR_TRACK = 2'b10
  } dsbr_lock_e;

endpackage : dsbr_pkg

// ==== rtl/dsbr_realigner.sv ====
// Receive channel: phase aligner, deserializer, free-running synchronizer and bit-slip realigner.
`timescale 1ns/100ps
module dsbr_realigner
  import dsbr_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic link_clk_in, // Link bit clock pin.
  input wire logic ser_data_in, // Serial data pin.
  input wire logic width_10_in, // Deserialization factor select, high for 10.
  input wire logic slip_req_in, // Slip request from pin or fabric.
  output dsbr_word_s word_out, // Realigned parallel word.
  output logic par_stb, // Parallel-clock enable pulse.
  output logic gbl_stb, // Global read clock enable pulse.
  output logic locked // Phase aligner has settled.
);

  logic [1:0] clk_sync_q;
  logic [1:0] dat_sync_q;
  logic [1:0] slip_sync_q;
  logic [1:0] wid_sync_q;
  logic clk_prev_q;
  logic dat_prev_q;

  // Every input pin except clock and nrst passes two flops before use.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_sync_q <= '0;
      dat_sync_q <= '0;
      slip_sync_q <= '0;
      wid_sync_q <= '0;
    end else begin
      clk_sync_q <= {clk_sync_q[0], link_clk_in};
      dat_sync_q <= {dat_sync_q[0], ser_data_in};
      slip_sync_q <= {slip_sync_q[0], slip_req_in};
      wid_sync_q <= {wid_sync_q[0], width_10_in};
    end
  end

  logic clk_s;
  logic dat_s;
  logic [3:0] jw;
  assign clk_s = clk_sync_q[1];
  assign dat_s = dat_sync_q[1];
  assign jw = wid_sync_q[1] ? DSBR_J10 : DSBR_J8;

  function automatic logic at_top(input logic [3:0] cnt, input logic [3:0] j);
    at_top = (cnt >= j - 4'h1);
  endfunction : at_top

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_prev_q <= 1'b0;
      dat_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
      dat_prev_q <= dat_s;
    end
  end

  logic clk_rise;
  logic dat_edge;
  assign clk_rise = clk_s & ~clk_prev_q;
  assign dat_edge = dat_s ^ dat_prev_q;

  // Phase counter splits each bit period into eight equally spaced samples.
  logic [DSBR_PH_W-1:0] ph_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_q <= '0;
    end else if (clk_rise) begin
      ph_q <= '0;
    end else if (ph_q != DSBR_PH_LAST) begin
      ph_q <= ph_q + 1'b1;
    end
  end

  // Data transitions are tracked without end; the sample point sits half a bit away.
  logic [DSBR_PH_W-1:0] edge_ph_q;
  logic [DSBR_PH_W-1:0] samp_ph;
  logic [4:0] agree_q;
  dsbr_lock_e lock_q;
  assign samp_ph = edge_ph_q + DSBR_PH_HALF;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      edge_ph_q <= '0;
    end else if (dat_edge) begin
      edge_ph_q <= ph_q;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      agree_q <= '0;
      lock_q <= DSBR_HUNT;
    end else if (dat_edge) begin
      case (lock_q)
        DSBR_HUNT: begin
          if (ph_q != edge_ph_q) begin
            agree_q <= '0;
          end else if (agree_q == DSBR_LOCK_EDGES - 5'h1) begin
            lock_q <= DSBR_TRACK;
          end else begin
            agree_q <= agree_q + 5'h1;
          end
        end
        DSBR_TRACK: begin
          agree_q <= '0;
        end
        default: begin
          lock_q <= DSBR_HUNT;
        end
      endcase
    end
  end
  assign locked = (lock_q == DSBR_TRACK);

  // Deserializer: first received bit lands in the top bit of the word.
  logic bit_stb;
  logic [3:0] bit_cnt_q;
  dsbr_word_t shift_q;
  dsbr_word_t par_word_q;
  logic par_stb_q;
  assign bit_stb = (ph_q == samp_ph);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
      par_word_q <= '0;
      par_stb_q <= 1'b0;
    end else begin
      par_stb_q <= 1'b0;
      if (bit_stb) begin
        shift_q <= {shift_q[DSBR_WMAX-2:0], dat_s};
        if (at_top(bit_cnt_q, jw)) begin
          bit_cnt_q <= '0;
          par_word_q <= {shift_q[DSBR_WMAX-2:0], dat_s} & ((10'h001 << jw) - 10'h001);
          par_stb_q <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
    end
  end
  assign par_stb = par_stb_q;

  // Global read strobe has the same rate as the parallel strobe, offset in phase.
  logic rd_stb;
  logic rd_stb_q;
  assign rd_stb = bit_stb && (bit_cnt_q == DSBR_RD_BIT);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_stb_q <= 1'b0;
    end else begin
      rd_stb_q <= rd_stb;
    end
  end
  assign gbl_stb = rd_stb_q;

  // Free-running pointers: no flags, no enables beyond the two clocks.
  logic [DSBR_PTR_W-1:0] wr_ptr_q;
  logic [DSBR_PTR_W-1:0] rd_ptr_q;
  dsbr_word_t sync_word;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= DSBR_WR_PTR_RST;
    end else if (par_stb_q) begin
      wr_ptr_q <= wr_ptr_q + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_ptr_q <= DSBR_RD_PTR_RST;
    end else if (rd_stb) begin
      rd_ptr_q <= rd_ptr_q + 2'h1;
    end
  end

  dsbr_sync_mem u_sync_mem (
    .clock(clock),
    .nrst(nrst),
    .wr_en(par_stb_q),
    .wr_addr(wr_ptr_q),
    .wr_data(par_word_q),
    .rd_en(rd_stb),
    .rd_addr(rd_ptr_q),
    .rd_data(sync_word)
  );

  // Selects J bits of the two slip registers, offset by the slip count.
  function automatic dsbr_word_t slip_sel(input dsbr_word_t older, input dsbr_word_t newer,
                                          input logic [3:0] j, input logic [3:0] cnt);
    logic [2*DSBR_WMAX-1:0] both;
    dsbr_word_t mask;
    both = ({10'h000, older} << j) | {10'h000, newer};
    mask = (10'h001 << j) - 10'h001;
    slip_sel = DSBR_WMAX'(both >> cnt) & mask;
  endfunction : slip_sel

  // Realigner: always in the path, per channel, slip edge sampled on the global strobe.
  dsbr_word_t slip2_q;
  dsbr_word_t slip3_q;
  logic slip_prev_q;
  logic [3:0] slip_cnt_q;
  logic slip_rise;
  assign slip_rise = rd_stb_q && slip_sync_q[1] && !slip_prev_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slip_prev_q <= 1'b0;
    end else if (rd_stb_q) begin
      slip_prev_q <= slip_sync_q[1];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slip2_q <= '0;
      slip3_q <= '0;
    end else if (rd_stb_q) begin
      slip2_q <= slip3_q;
      slip3_q <= sync_word;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slip_cnt_q <= '0;
    end else if (slip_rise) begin
      if (at_top(slip_cnt_q, jw)) begin
        slip_cnt_q <= '0;
      end else begin
        slip_cnt_q <= slip_cnt_q + 4'h1;
      end
    end
  end

  // Output register adds latency only while the slip count is zero.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      word_out <= '0;
    end else begin
      word_out.valid <= 1'b0;
      if (rd_stb_q) begin
        word_out.data <= slip_sel(slip2_q, slip3_q, jw, slip_cnt_q);
        word_out.valid <= !(slip_rise && at_top(slip_cnt_q, jw));
      end
    end
  end

endmodule : dsbr_realigner

// ==== rtl/dsbr_sync_mem.sv ====
// Four-entry word store of the phase synchronizer with registered read data.
`timescale 1ns/100ps
module dsbr_sync_mem
  import dsbr_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic wr_en, // Parallel-rate write strobe.
  input wire logic [DSBR_PTR_W-1:0] wr_addr, // Write entry.
  input wire dsbr_word_t wr_data, // Word written.
  input wire logic rd_en, // Global-rate read strobe.
  input wire logic [DSBR_PTR_W-1:0] rd_addr, // Read entry.
  output dsbr_word_t rd_data // Registered read word.
);

  dsbr_word_t mem_q [DSBR_FIFO_DEPTH];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DSBR_FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : dsbr_sync_mem

// ==== tb/dsbr_link_tx.sv ====
// Source-synchronous transmitter model, words sent most significant bit first.
`timescale 1ns/100ps
module dsbr_link_tx
  import dsbr_pkg::*;
(
  output logic link_clk, // Free-running bit clock.
  output logic ser_data, // Serial data.
  input wire logic width_10, // High for ten-bit words.
  input wire dsbr_word_t tx_word // Word taken at each boundary.
);
  int unsigned bit_idx;
  dsbr_word_t cur;
  initial begin
    link_clk = 1'b0;
    ser_data = 1'b0;
    bit_idx = 0;
    cur = '0;
    #13.3;
    forever begin
      #40 link_clk = ~link_clk;
      if (!link_clk) begin
        if (bit_idx >= (width_10 ? 10 : 8)) bit_idx = 0;
        if (bit_idx == 0) cur = tx_word;
        ser_data = cur[(width_10 ? 9 : 7) - bit_idx];
        bit_idx++;
      end
    end
  end
endmodule : dsbr_link_tx

// ==== tb/dsbr_realigner_asserts.sv ====
// Port assertions of the realigning receive channel.
`timescale 1ns/100ps
module dsbr_realigner_asserts
  import dsbr_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic nrst, // Reset.
  input wire logic width_10_in, // Width.
  input wire logic slip_req_in, // Slip.
  input wire dsbr_word_s word_out, // Word.
  input wire logic par_stb, // Write pulse.
  input wire logic gbl_stb, // Read pulse.
  input wire logic locked // Lock.
);
  logic [7:0] gap_q;
  logic [7:0] up_q;
  logic [1:0] seen_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 8'h00;
      up_q <= 8'h00;
    end else begin
      gap_q <= par_stb ? 8'h01 : gap_q + {7'h00, gap_q != 8'hff};
      up_q <= up_q + {7'h00, up_q != 8'hff};
    end
  end
  // Word spacing is only judged once the aligner has settled.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 2'h0;
    end else if (par_stb && locked && seen_q != 2'h3) begin
      seen_q <= seen_q + 2'h1;
    end
  end
  lock_hold_a: assert property (locked |=> locked) else $error("lock dropped");
  lock_delay_a: assert property (locked |-> up_q >= 8'h78) else $error("early lock");
  valid_read_a: assert property (word_out.valid |-> $past(gbl_stb)) else $error("stray valid");
  read_follows_a: assert property (par_stb |-> ##[1:90] gbl_stb) else $error("no read");
  read_pulse_a: assert property (gbl_stb |=> !gbl_stb [*8]) else $error("read too soon");
  word_period_a: assert property (par_stb && seen_q == 2'h3 |->
    gap_q == (width_10_in ? 8'h50 : 8'h40)) else $error("bad word period");
  narrow_zero_a: assert property (word_out.valid && !width_10_in |->
    word_out.data[9:8] == 2'h0) else $error("upper bits set");
  valid_pulse_a: assert property (word_out.valid |=> !word_out.valid) else $error("long valid");
  cover property (word_out.valid && width_10_in);
  cover property ($rose(slip_req_in) && locked);
  cover property ($rose(locked));
endmodule : dsbr_realigner_asserts

bind dsbr_realigner dsbr_realigner_asserts u_asserts (.clock, .nrst, .width_10_in,
  .slip_req_in, .word_out, .par_stb, .gbl_stb, .locked);

// ==== tb/dsbr_realigner_tb.sv ====
// Self-checking bench of the realigning receive channel.
`timescale 1ns/100ps
module dsbr_realigner_tb
  import dsbr_pkg::*;
;
  logic clock;
  logic nrst;
  logic width_10_in;
  logic slip_req_in;
  logic link_clk_in;
  logic ser_data_in;
  dsbr_word_t tx_word;
  dsbr_word_s word_out;
  logic par_stb;
  logic gbl_stb;
  logic locked;
  int bad_count;
  int cmp_count;
  int cyc;
  dsbr_realigner DUT (.clock, .nrst, .link_clk_in, .ser_data_in, .width_10_in,
    .slip_req_in, .word_out, .par_stb, .gbl_stb, .locked);
  dsbr_link_tx u_tx (.link_clk(link_clk_in), .ser_data(ser_data_in),
    .width_10(width_10_in), .tx_word(tx_word));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  function automatic dsbr_word_t rotr(dsbr_word_t w, int unsigned j, int unsigned k);
    dsbr_word_t r = '0;
    for (int i = 0; i < j; i++) r[i] = w[(i + k) % j];
    return r;
  endfunction : rotr
  // A pattern equal to one of its own rotations would hide a lost slip.
  function automatic bit aper(dsbr_word_t w, int unsigned j);
    for (int k = 1; k < j; k++) if (rotr(w, j, k) == w) return 1'b0;
    return 1'b1;
  endfunction : aper
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic chk_word(dsbr_word_t got, dsbr_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(logic got, logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic get_word(output dsbr_word_t w);
    int n = 0;
    do @(negedge clock); while (word_out.valid !== 1'b1 && ++n < 300);
    chk_bit(word_out.valid, 1'b1);
    w = word_out.data;
  endtask : get_word
  task automatic slip(int unsigned j);
    do @(negedge clock); while (gbl_stb !== 1'b1);
    slip_req_in = 1'b1;
    repeat (2 * j * 8 + 8) @(negedge clock);
    slip_req_in = 1'b0;
    repeat (3 * j * 8 + 8) @(negedge clock);
  endtask : slip
  initial begin
    dsbr_word_t p;
    dsbr_word_t w;
    int unsigned j;
    int r0;
    clock = 1'b0;
    nrst = 1'b0;
    width_10_in = 1'b0;
    slip_req_in = 1'b0;
    tx_word = '0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'h6fd6_c530));
    for (int m = 0; m < 2; m++) begin
      j = m ? 10 : 8;
      @(negedge clock);
      nrst = 1'b0;
      width_10_in = m[0];
      tx_word = m ? 10'h2aa : 10'h00f;
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      for (int n = 0; n < 3000 && locked !== 1'b1; n++) @(negedge clock);
      chk_bit(locked, 1'b1);
      do p = dsbr_word_t'($urandom) & dsbr_word_t'((1 << j) - 1);
      while (!aper(p, j));
      tx_word = p;
      repeat (8) get_word(w);
      r0 = 0;
      for (int k = 0; k < j; k++) if (rotr(p, j, k) == w) r0 = k;
      for (int i = 0; i < 3; i++) begin
        get_word(w);
        chk_word(w, rotr(p, j, r0));
      end
      for (int s = 1; s <= j; s++) begin
        slip(j);
        get_word(w);
        get_word(w);
        chk_word(w, rotr(p, j, (r0 + s) % j));
      end
      // Fabric-style search: slip until the sent word appears unrotated.
      for (int t = 0; t < j && w !== p; t++) begin
        slip(j);
        get_word(w);
        get_word(w);
      end
      chk_word(w, p);
      $display("width %0d test done", j);
    end
    stop_test();
  end
endmodule : dsbr_realigner_tb
